/* File: msc_pkg.sv */
package msc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] ADDR_HW_CONFIG   = 7'h02;
  localparam logic [7:0] MODE_RESET_VAL   = 8'h00;
  localparam logic [7:0] HW_RESET_VAL     = 8'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;
  // restart keeps bits 5,1,0 of the mode register
  localparam logic [7:0] MODE_RESTART_KEEP = 8'h23;
  // restart keeps bits 7,6,4,3,0 of the hardware register
  localparam logic [7:0] HW_RESTART_KEEP   = 8'hD9;
  // soft reset keeps bits 7 and 3 of the hardware register
  localparam logic [7:0] HW_SOFT_KEEP      = 8'h88;
  // reserved bit 2 of the hardware register
  localparam logic [7:0] HW_WRITE_MASK     = 8'hFB;

  // ----------------------------------------------------------------
  // serial frame
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS  = 5'h10;
  localparam logic [4:0] ADDR_BITS   = 5'h08;
  localparam logic [4:0] ADDR_LAST   = 5'h07;
  localparam logic [7:0] SPI_STATUS  = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 50;
  localparam int SOFT_RST_NS = 2000;
  localparam int SOFT_RST_CYC_I = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SOFT_RST_CYC = SOFT_RST_CYC_I[7:0];
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [1:0] WD_CNT_ONE   = 2'h1;
  localparam logic [1:0] WD_CNT_TWO   = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSC_NORMAL     = 2'h0,
    MSC_SLEEP      = 2'h1,
    MSC_STOP       = 2'h2,
    MSC_SOFT_RESET = 2'h3
  } msc_mode_e;

  typedef enum logic [1:0] {
    MSC_SR_OFF        = 2'h0,
    MSC_SR_NORMAL     = 2'h1,
    MSC_SR_NORM_STOP  = 2'h2,
    MSC_SR_ALWAYS     = 2'h3
  } msc_second_e;

  typedef enum logic {
    MSC_SEQ_IDLE = 1'b0,
    MSC_SEQ_SOFT = 1'b1
  } msc_seq_e;

  typedef struct packed {
    msc_mode_e   chip_mode;
    logic        third_reg_enable;
    msc_second_e second_reg_ctrl;
    logic        primary_ov_restart_en;
    logic [1:0]  primary_reset_threshold;
  } msc_mode_reg_s;

  typedef struct packed {
    logic third_reg_voltage_sel;
    logic soft_reset_no_rst_out;
    logic fail_out_sw_activate;
    logic third_reg_keep_on_uv;
    logic third_reg_load_share;
    logic reserved;
    logic third_reg_share_in_stop;
    logic wd_first_fail_cfg;
  } msc_hw_reg_s;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } msc_cmd_s;

  typedef struct packed {
    logic       second_reg_on;
    logic       third_reg_on;
    logic       third_reg_voltage_sel;
    logic       third_reg_load_share;
    logic       third_reg_share_in_stop;
    logic [1:0] primary_reset_threshold;
  } msc_supply_s;

endpackage

/* File: msc_spi_frame.sv */
`timescale 1ns/1ps
`default_nettype none

module msc_spi_frame
(
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire logic             i_ce,
  input  wire logic             i_csn,
  input  wire logic             i_sclk,
  input  wire logic             i_sdi,
  output logic                  o_sdo,
  output logic                  o_sdo_oe,
  output logic [6:0]            o_addr,
  input  wire logic [7:0]       i_rdata,
  output msc_pkg::msc_cmd_s     o_cmd,
  output logic                  o_cmd_valid
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sclk;
    logic        csn;
    logic [4:0]  cnt;
    logic [15:0] rx;
    logic [7:0]  tx;
  } msc_frm_s;

  msc_frm_s s_q;
  msc_frm_s s_d;
  logic     rise;
  logic     done;

  assign rise = i_sclk & ~s_q.sclk & ~i_csn;
  // frame counts only if sixteen or more clocks came before deselect
  assign done = i_csn & ~s_q.csn & (s_q.cnt == msc_pkg::FRAME_BITS);

  always_comb
  begin
    s_d      = s_q;
    s_d.sclk = i_sclk;
    s_d.csn  = i_csn;
    if (i_csn)
    begin
      s_d.cnt = '0;
      s_d.tx  = msc_pkg::SPI_STATUS;
    end
    else if (rise)
    begin
      // lsb first: bits 6:0 address, bit 7 access, then data
      s_d.rx = {i_sdi, s_q.rx[15:1]};
      if (s_q.cnt != msc_pkg::FRAME_BITS)
        s_d.cnt = s_q.cnt + 5'h01;
      // old contents captured before any write lands
      if (s_q.cnt == msc_pkg::ADDR_LAST)
        s_d.tx = i_rdata;
      else
        s_d.tx = {1'b0, s_q.tx[7:1]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '{sclk: 1'b0, csn: 1'b1, cnt: 5'h00, rx: 16'h0000, tx: 8'h00};
    end
    else if (i_ce)
    begin
      s_q <= s_d;
    end
  end

  // address of the byte being clocked in, valid at the eighth edge
  // seven address bits already shifted in; i_sdi holds the access bit here
  assign o_addr      = (s_q.cnt == msc_pkg::ADDR_LAST) ? s_q.rx[15:9]
                                                       : s_q.rx[6:0];
  assign o_cmd.wr    = s_q.rx[7];
  assign o_cmd.addr  = s_q.rx[6:0];
  assign o_cmd.data  = s_q.rx[15:8];
  assign o_cmd_valid = done & i_ce;
  assign o_sdo       = s_q.tx[0];
  assign o_sdo_oe    = ~i_csn;

endmodule

`default_nettype wire

/* File: msc_mode_supply_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module msc_mode_supply_regs
(
  input  wire logic                i_mclk,
  input  wire logic                i_nrst,
  input  wire logic                i_ce,
  input  wire logic                i_spi_csn,
  input  wire logic                i_spi_sclk,
  input  wire logic                i_spi_sdi,
  output logic                     o_spi_sdo,
  output logic                     o_spi_sdo_oe,
  input  wire msc_pkg::msc_mode_e  i_cur_mode,
  input  wire logic                i_fail_safe,
  input  wire logic                i_restart_entry,
  input  wire logic                i_overtemp,
  input  wire logic                i_vs_uv,
  input  wire logic                i_primary_ov,
  input  wire logic                i_primary_ov_flag_clr,
  input  wire logic                i_wd_trig_fail,
  input  wire logic                i_failure_flag,
  output msc_pkg::msc_mode_e       o_mode_req,
  output logic                     o_mode_req_valid,
  output msc_pkg::msc_supply_s     o_supply,
  output logic                     o_primary_ov_flag,
  output logic                     o_ov_restart_req,
  output logic                     o_wd_restart_req,
  output logic                     o_soft_reset_active,
  output logic                     o_reset_output_n,
  output logic                     o_failure_outputs
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    msc_pkg::msc_mode_reg_s mode;
    msc_pkg::msc_hw_reg_s   hw;
    msc_pkg::msc_seq_e      seq;
    logic [7:0]             soft_cnt;
    logic                   rst_out_n;
    logic                   ov_flag;
    logic                   ov_req;
    logic [1:0]             wd_cnt;
    logic                   wd_req;
    msc_pkg::msc_mode_e     req;
    logic                   req_valid;
    msc_pkg::msc_supply_s   sup;
    logic                   fail_out;
  } msc_state_s;

  msc_state_s             s_q;
  msc_state_s             s_d;
  logic [6:0]             rd_addr;
  logic [7:0]             rdata;
  msc_pkg::msc_cmd_s      cmd;
  logic                   cmd_valid;
  msc_pkg::msc_mode_reg_s wmode;
  msc_pkg::msc_hw_reg_s   whw;

  // ----------------------------------------------------------------
  // serial front end
  // ----------------------------------------------------------------
  msc_spi_frame u_frame
  (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_ce        (i_ce),
    .i_csn       (i_spi_csn),
    .i_sclk      (i_spi_sclk),
    .i_sdi       (i_spi_sdi),
    .o_sdo       (o_spi_sdo),
    .o_sdo_oe    (o_spi_sdo_oe),
    .o_addr      (rd_addr),
    .i_rdata     (rdata),
    .o_cmd       (cmd),
    .o_cmd_valid (cmd_valid)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    if (rd_addr == msc_pkg::ADDR_MODE_SUPPLY)
      rdata = s_q.mode;
    else if (rd_addr == msc_pkg::ADDR_HW_CONFIG)
      rdata = s_q.hw & msc_pkg::HW_WRITE_MASK;
    else
      rdata = msc_pkg::READ_ZERO;
  end

  assign wmode = cmd.data;
  assign whw   = cmd.data & msc_pkg::HW_WRITE_MASK;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d           = s_q;
    s_d.req_valid = 1'b0;
    s_d.wd_req    = 1'b0;

    // serial writes
    if (cmd_valid && cmd.wr)
    begin
      if (cmd.addr == msc_pkg::ADDR_MODE_SUPPLY)
      begin
        s_d.mode.third_reg_enable        = wmode.third_reg_enable;
        s_d.mode.second_reg_ctrl         = wmode.second_reg_ctrl;
        s_d.mode.primary_ov_restart_en   = wmode.primary_ov_restart_en;
        s_d.mode.primary_reset_threshold = wmode.primary_reset_threshold;
        // stop cannot go to sleep by command; field keeps old code
        if (!(i_cur_mode == msc_pkg::MSC_STOP && wmode.chip_mode == msc_pkg::MSC_SLEEP))
        begin
          s_d.mode.chip_mode = wmode.chip_mode;
          s_d.req            = wmode.chip_mode;
          s_d.req_valid      = (wmode.chip_mode != msc_pkg::MSC_SOFT_RESET);
        end
        if (wmode.chip_mode == msc_pkg::MSC_SOFT_RESET && s_q.seq == msc_pkg::MSC_SEQ_IDLE)
        begin
          s_d.seq       = msc_pkg::MSC_SEQ_SOFT;
          s_d.soft_cnt  = msc_pkg::SOFT_RST_CYC;
          // reset output behaviour follows the setting in force now
          s_d.rst_out_n = s_q.hw.soft_reset_no_rst_out;
        end
      end
      else if (cmd.addr == msc_pkg::ADDR_HW_CONFIG)
      begin
        s_d.hw = whw;
      end
    end

    // soft reset sequencer
    case (s_q.seq)
      msc_pkg::MSC_SEQ_IDLE:
      begin
        s_d.soft_cnt = s_d.soft_cnt;
      end
      msc_pkg::MSC_SEQ_SOFT:
      begin
        s_d.soft_cnt = s_q.soft_cnt - msc_pkg::CNT_ONE;
        if (s_q.soft_cnt == msc_pkg::CNT_ONE)
        begin
          s_d.seq       = msc_pkg::MSC_SEQ_IDLE;
          s_d.rst_out_n = 1'b1;
          s_d.mode      = msc_pkg::MODE_RESET_VAL;
          s_d.hw        = s_q.hw & msc_pkg::HW_SOFT_KEEP;
          s_d.wd_cnt    = '0;
          s_d.req       = msc_pkg::MSC_NORMAL;
          s_d.req_valid = 1'b1;
        end
      end
      default:
      begin
        s_d.seq = msc_pkg::MSC_SEQ_IDLE;
      end
    endcase

    // overtemperature switches the second regulator off
    if (i_overtemp)
      s_d.mode.second_reg_ctrl = msc_pkg::MSC_SR_OFF;

    // restart entry: hardware owns these fields over any write
    if (i_restart_entry)
    begin
      s_d.mode           = s_q.mode & msc_pkg::MODE_RESTART_KEEP;
      s_d.mode.chip_mode = msc_pkg::MSC_NORMAL;
      s_d.mode.second_reg_ctrl = msc_pkg::MSC_SR_OFF;
      s_d.hw             = s_q.hw & msc_pkg::HW_RESTART_KEEP;
      s_d.hw.fail_out_sw_activate = 1'b0;
      s_d.wd_cnt         = '0;
    end

    // overvoltage flag: set wins over clear
    if (i_primary_ov)
      s_d.ov_flag = 1'b1;
    else if (i_primary_ov_flag_clr)
      s_d.ov_flag = 1'b0;
    s_d.ov_req = i_primary_ov & s_q.mode.primary_ov_restart_en;

    // watchdog failures tolerated before restart
    if (i_wd_trig_fail && !i_restart_entry)
    begin
      if (s_q.hw.wd_first_fail_cfg || s_q.wd_cnt == msc_pkg::WD_CNT_ONE)
      begin
        s_d.wd_req = 1'b1;
        s_d.wd_cnt = '0;
      end
      else
      begin
        s_d.wd_cnt = msc_pkg::WD_CNT_ONE;
      end
    end

    // second regulator by mode
    case (s_q.mode.second_reg_ctrl)
      msc_pkg::MSC_SR_OFF:       s_d.sup.second_reg_on = 1'b0;
      msc_pkg::MSC_SR_NORMAL:    s_d.sup.second_reg_on = (i_cur_mode == msc_pkg::MSC_NORMAL);
      msc_pkg::MSC_SR_NORM_STOP: s_d.sup.second_reg_on = (i_cur_mode == msc_pkg::MSC_NORMAL) ||
                                                         (i_cur_mode == msc_pkg::MSC_STOP);
      msc_pkg::MSC_SR_ALWAYS:    s_d.sup.second_reg_on = ~i_fail_safe;
      default:                   s_d.sup.second_reg_on = 1'b0;
    endcase

    // third regulator
    s_d.sup.third_reg_on = s_q.mode.third_reg_enable &
                           ~(i_vs_uv & ~s_q.hw.third_reg_keep_on_uv);
    s_d.sup.third_reg_voltage_sel   = s_q.hw.third_reg_voltage_sel;
    s_d.sup.third_reg_load_share    = s_q.hw.third_reg_load_share;
    s_d.sup.third_reg_share_in_stop = s_q.hw.third_reg_share_in_stop;
    s_d.sup.primary_reset_threshold = s_q.mode.primary_reset_threshold;

    // failure outputs follow the software bit or the failure flag input
    s_d.fail_out = s_q.hw.fail_out_sw_activate | i_failure_flag;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q.mode      <= msc_pkg::MODE_RESET_VAL;
      s_q.hw        <= msc_pkg::HW_RESET_VAL;
      s_q.seq       <= msc_pkg::MSC_SEQ_IDLE;
      s_q.soft_cnt  <= '0;
      s_q.rst_out_n <= 1'b1;
      s_q.ov_flag   <= 1'b0;
      s_q.ov_req    <= 1'b0;
      s_q.wd_cnt    <= '0;
      s_q.wd_req    <= 1'b0;
      s_q.req       <= msc_pkg::MSC_NORMAL;
      s_q.req_valid <= 1'b0;
      s_q.sup       <= '0;
      s_q.fail_out  <= 1'b0;
    end
    else if (i_ce)
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_mode_req          = s_q.req;
  assign o_mode_req_valid    = s_q.req_valid;
  assign o_supply            = s_q.sup;
  assign o_primary_ov_flag   = s_q.ov_flag;
  assign o_ov_restart_req    = s_q.ov_req;
  assign o_wd_restart_req    = s_q.wd_req;
  assign o_soft_reset_active = (s_q.seq == msc_pkg::MSC_SEQ_SOFT);
  assign o_reset_output_n    = s_q.rst_out_n;
  assign o_failure_outputs   = s_q.fail_out;

endmodule

`default_nettype wire

/* File: msc_mode_supply_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// port checker
// --------------------------------------------
module msc_mode_supply_regs_properties
(
  input wire logic                 i_mclk,
  input wire logic                 i_nrst,
  input wire logic                 i_restart_entry,
  input wire logic                 i_overtemp,
  input wire logic                 i_primary_ov,
  input wire logic                 i_wd_trig_fail,
  input wire logic                 i_failure_flag,
  input wire msc_pkg::msc_mode_e   i_cur_mode,
  input wire msc_pkg::msc_mode_e   o_mode_req,
  input wire logic                 o_mode_req_valid,
  input wire msc_pkg::msc_supply_s o_supply,
  input wire logic                 o_primary_ov_flag,
  input wire logic                 o_wd_restart_req,
  input wire logic                 o_soft_reset_active,
  input wire logic                 o_reset_output_n,
  input wire logic                 o_failure_outputs
);
  // length of a soft reset, too long for a repetition
  logic [7:0] act_cnt_q;
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      act_cnt_q <= 8'h00;
    else
      act_cnt_q <= o_soft_reset_active ? act_cnt_q + 8'h01 : 8'h00;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_hw_clear; i_restart_entry || i_overtemp; endsequence
  sequence s_restart_idle; i_restart_entry ##1 !i_failure_flag; endsequence

  property p_second_clear; s_hw_clear |-> ##2 !o_supply.second_reg_on; endproperty
  property p_fail_release; s_restart_idle |=> !o_failure_outputs; endproperty
  property p_fail_flag; i_failure_flag |=> o_failure_outputs; endproperty
  property p_ov_flag; i_primary_ov |=> o_primary_ov_flag; endproperty
  property p_wd_cause; o_wd_restart_req |-> $past(i_wd_trig_fail); endproperty
  property p_rst_out;
    !o_reset_output_n |-> o_soft_reset_active || $past(o_soft_reset_active);
  endproperty
  property p_soft_len; $fell(o_soft_reset_active) |-> act_cnt_q == 8'h64; endproperty
  property p_no_stop_sleep;
    o_mode_req_valid && o_mode_req == msc_pkg::MSC_SLEEP
      |-> $past(i_cur_mode) != msc_pkg::MSC_STOP;
  endproperty

  a_second_clear: assert property (p_second_clear) else $error("second reg stays on");
  a_fail_release: assert property (p_fail_release) else $error("fail out kept");
  a_fail_flag: assert property (p_fail_flag) else $error("fail out not driven");
  a_ov_flag: assert property (p_ov_flag) else $error("ov flag not set");
  a_wd_cause: assert property (p_wd_cause) else $error("spurious wd restart");
  a_rst_out: assert property (p_rst_out) else $error("reset out outside soft reset");
  a_soft_len: assert property (p_soft_len) else $error("soft reset length");
  a_no_stop_sleep: assert property (p_no_stop_sleep) else $error("stop to sleep");
endmodule

bind msc_mode_supply_regs msc_mode_supply_regs_properties msc_props_inst
  (.i_mclk, .i_nrst, .i_restart_entry, .i_overtemp, .i_primary_ov, .i_wd_trig_fail,
   .i_failure_flag, .i_cur_mode, .o_mode_req, .o_mode_req_valid, .o_supply,
   .o_primary_ov_flag, .o_wd_restart_req, .o_soft_reset_active, .o_reset_output_n,
   .o_failure_outputs);
`default_nettype wire

/* File: msc_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// host spi master
// --------------------------------------------
module msc_spi_host
(
  input  wire logic i_mclk,
  input  wire logic i_sdo,
  output logic      o_csn,
  output logic      o_sclk,
  output logic      o_sdi
);
  initial
  begin
    o_csn  = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end

  // address, access bit, data byte, lsb first
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                      input int nclk, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wdata, wr, addr};
    @(posedge i_mclk) o_csn <= 1'b0;
    for (int i = 0; i <= nclk; i++)
    begin
      @(posedge i_mclk);
      if (i < nclk)
        o_sdi <= frame[i];
      repeat (2) @(posedge i_mclk);
      // bit before this rise is still settled here
      if (i >= 8 && i < 16)
        rdata[i-8] = i_sdo;
      if (i < nclk)
        o_sclk <= 1'b1;
      else
        o_csn <= 1'b1;
      repeat (2) @(posedge i_mclk);
      o_sclk <= 1'b0;
    end
    // released line must not look like held data
    o_sdi <= ~o_sdi;
    repeat (2) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

/* File: msc_mode_supply_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// testbench
// --------------------------------------------
module msc_mode_supply_regs_tb;
  logic                 i_mclk, i_nrst, csn, sclk, sdi, sdo;
  logic                 fail_safe, vs_uv, ov, ov_clr, fflag, mode_vld;
  logic                 ov_flag, ov_req, wd_req, sr_act, rst_n, fout;
  logic [2:0]           pls;
  logic [7:0]           mode_m, hw_m, rd, d;
  logic [31:0]          r;
  msc_pkg::msc_mode_e   cur_mode, mode_req;
  msc_pkg::msc_supply_s sup;
  int                   num_errors, samples_checked, wd_seen;

  msc_spi_host msc_spi_host_inst (.i_mclk(i_mclk), .i_sdo(sdo), .o_csn(csn),
    .o_sclk(sclk), .o_sdi(sdi));
  msc_mode_supply_regs msc_mode_supply_regs_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_ce(1'b1), .i_spi_csn(csn), .i_spi_sclk(sclk), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
    .o_spi_sdo_oe(), .i_cur_mode(cur_mode), .i_fail_safe(fail_safe),
    .i_restart_entry(pls[2]), .i_overtemp(pls[1]), .i_vs_uv(vs_uv), .i_primary_ov(ov),
    .i_primary_ov_flag_clr(ov_clr), .i_wd_trig_fail(pls[0]), .i_failure_flag(fflag),
    .o_mode_req(mode_req), .o_mode_req_valid(mode_vld), .o_supply(sup),
    .o_primary_ov_flag(ov_flag), .o_ov_restart_req(ov_req), .o_wd_restart_req(wd_req),
    .o_soft_reset_active(sr_act), .o_reset_output_n(rst_n), .o_failure_outputs(fout));

  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  always @(negedge i_mclk)
    if (wd_req === 1'b1)
      wd_seen++;

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string nm);
    msc_spi_host_inst.xfer(1'b0, a, 8'hFF, 16, rd);
    chk(nm, exp, rd);
  endtask

  task automatic wm(input logic [7:0] v);
    msc_spi_host_inst.xfer(1'b1, 7'h01, v, 16, rd);
    chk("mode write echo", mode_m, rd);
    if (v[7:6] == 2'h1 && cur_mode == msc_pkg::MSC_STOP)
      v[7:6] = mode_m[7:6];
    mode_m = v;
  endtask

  task automatic wh(input logic [7:0] v);
    msc_spi_host_inst.xfer(1'b1, 7'h02, v, 16, rd);
    chk("hw write echo", hw_m, rd);
    hw_m = v & 8'hFB;
  endtask

  task automatic pulse(input logic [2:0] p);
    @(posedge i_mclk) pls <= p;
    @(posedge i_mclk) pls <= 3'h0;
    repeat (3) @(posedge i_mclk);
  endtask

  function automatic logic [7:0] sup_exp();
    logic on2;
    case (mode_m[4:3])
      2'h0:    on2 = 1'b0;
      2'h1:    on2 = cur_mode == msc_pkg::MSC_NORMAL;
      2'h2:    on2 = cur_mode inside {msc_pkg::MSC_NORMAL, msc_pkg::MSC_STOP};
      default: on2 = !fail_safe;
    endcase
    return {1'b0, on2, mode_m[5] && !(vs_uv && !hw_m[4]), hw_m[7], hw_m[3], hw_m[1],
            mode_m[1:0]};
  endfunction

  initial
  begin
    {i_nrst, fail_safe, vs_uv, ov, ov_clr, fflag, pls} = '0;
    cur_mode = msc_pkg::MSC_NORMAL;
    {num_errors, samples_checked, wd_seen} = '0;
    mode_m = 8'h00;
    hw_m = 8'h00;
    r = $urandom(29);
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rdc(7'h01, 8'h00, "mode reset value");
    rdc(7'h02, 8'h00, "hw reset value");
    for (int k = 0; k < 24; k++)
    begin
      r = $urandom;
      @(posedge i_mclk);
      cur_mode <= msc_pkg::msc_mode_e'(r[1:0] % 2'h3);
      fail_safe <= (r[1:0] % 2'h3 == 2'h1) && r[2];
      vs_uv <= r[3];
      wh(r[23:16]);
      d = r[15:8];
      d[7:6] = r[25:24] % 2'h3;
      wm(d);
      repeat (2) @(posedge i_mclk);
      chk("supply", sup_exp(), {1'b0, sup});
      chk("mode request", {6'h00, mode_m[7:6]}, {6'h00, mode_req});
    end
    @(posedge i_mclk) {cur_mode, fail_safe, vs_uv} <= '0;
    wh(8'hFB);
    wm(8'h3F);
    pulse(3'h4);
    mode_m &= 8'h23;
    hw_m &= 8'hD9;
    rdc(7'h01, mode_m, "mode after restart");
    rdc(7'h02, hw_m, "hw after restart");
    chk("fail out after restart", 8'h00, {7'h00, fout});
    for (int c = 0; c < 2; c++)
    begin
      wh({7'h00, c[0]});
      wd_seen = 0;
      pulse(3'h1);
      pulse(3'h1);
      chk("watchdog restarts", c[0] ? 8'h02 : 8'h01, wd_seen[7:0]);
    end
    wm(8'h18);
    pulse(3'h2);
    mode_m &= 8'hE7;
    rdc(7'h01, mode_m, "mode after overtemp");
    wh(8'h20);
    chk("fail out by sw", 8'h01, {7'h00, fout});
    @(posedge i_mclk) fflag <= 1'b1;
    wh(8'h00);
    chk("fail out held by flag", 8'h01, {7'h00, fout});
    @(posedge i_mclk) fflag <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk("fail out released", 8'h00, {7'h00, fout});
    for (int b = 0; b < 2; b++)
    begin
      wm(b[0] ? 8'h04 : 8'h00);
      @(posedge i_mclk) ov <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk("ov restart request", {7'h00, b[0]}, {7'h00, ov_req});
      @(posedge i_mclk) ov <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk("ov flag sticky", 8'h01, {7'h00, ov_flag});
      @(posedge i_mclk) ov_clr <= 1'b1;
      @(posedge i_mclk) ov_clr <= 1'b0;
      repeat (2) @(posedge i_mclk);
      chk("ov flag cleared", 8'h00, {7'h00, ov_flag});
    end
    for (int b = 0; b < 2; b++)
    begin
      wh(b[0] ? 8'hDB : 8'h9B);
      wm(8'hC0);
      repeat (10) @(posedge i_mclk);
      chk("reset output", {7'h00, b[0]}, {7'h00, rst_n});
      repeat (100) @(posedge i_mclk);
      mode_m = 8'h00;
      hw_m &= 8'h88;
      rdc(7'h01, mode_m, "mode after soft reset");
      rdc(7'h02, hw_m, "hw after soft reset");
    end
    msc_spi_host_inst.xfer(1'b1, 7'h02, 8'hFF, 15, rd);
    rdc(7'h02, hw_m, "hw after short frame");
    msc_spi_host_inst.xfer(1'b1, 7'h03, 8'hFF, 16, rd);
    rdc(7'h03, 8'h00, "unmapped read");
    rdc(7'h01, mode_m, "mode after unmapped write");
    conclude();
  end

  initial
  begin
    #1500000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
